// ===== include/gate_supervisor_regs.svh
`ifndef GATE_SUPERVISOR_REGS_SVH
`define GATE_SUPERVISOR_REGS_SVH

// core clock rate
`define GS_CLK_MHZ           50

// register byte offsets
`define GS_ADDR_FAULT        8'h00
`define GS_ADDR_CONTROL      8'h08
`define GS_ADDR_STATE        8'h0C

// fault status fields
`define GS_FLT_ANY           7
`define GS_FLT_WATCHDOG      6
`define GS_FLT_GATE_STUCK    5
`define GS_FLT_OVERLOAD      4
`define GS_FLT_SUPPLY_LOW    3
`define GS_FLT_PUMP_LOW      2
`define GS_FLT_THERMAL       1
`define GS_FLT_OTW           0

// control fields
`define GS_CTL_CLEAR         0
`define GS_CTL_IVL_LSB       1
`define GS_CTL_IVL_MSB       2
`define GS_CTL_WATCHDOG_ENABLE_BIT         3

// control reset values
`define GS_RST_WATCHDOG_ENABLE_BIT         1'b0
`define GS_RST_IVL           2'h0

// state register fields
`define GS_ST_MODE_LSB       0
`define GS_ST_GATE_I_LSB     2
`define GS_ST_VDS_LSB        5
`define GS_ST_ASLEEP         8
`define GS_ST_HALT           9
`define GS_ST_RETRY          10

// fixed settings of the pin-configured variant
`define GS_WD_PULSE_US       64
`define GS_CHOP_OFF_US       25
`define GS_VREF_PCT          100
`define GS_AMP_GAIN_X10      198
`define GS_VDS_DISABLED      3'h5

// bus answers
`define GS_RESP_OKAY         2'h0
`define GS_RESP_SLVERR       2'h2

`endif

// ===== include/gate_supervisor_pkg.sv
package gate_supervisor_pkg;

    typedef enum logic [4:0] {
        ST_POWER_ON   = 5'b00001,
        ST_ACTIVE     = 5'b00010,
        ST_SLEEP_WAIT = 5'b00100,
        ST_SLEEP      = 5'b01000,
        ST_WAKE       = 5'b10000
    } power_state_e;

    typedef enum logic [1:0] {
        MODE_PHASE_ENABLE = 2'h0,
        MODE_HALF_BRIDGE  = 2'h1,
        MODE_PWM          = 2'h2
    } control_mode_e;

    typedef logic [31:0] count_t;

endpackage : gate_supervisor_pkg

// ===== design/gate_driver_fault_supervisor.sv
// What this block does
// - watchdog is off after reset; software enables it by writing its enable bit.
// - enabled watchdog counts down over the interval picked by the interval field.
// - reading the fault register at offset zero refreshes the watchdog.
// - on expiry the watchdog trip output goes low for 64 us.
// - expiry pulls the error output low, clears the enable bit, halts the bridge.
// - watchdog flag and halt persist until the clear-errors bit is written 1.
// - watchdog fault disables only the bridge; pump and regulators keep running.
// - FET overload disables only the bridge; drive resumes after the retry time.
// - stuck gate raises a flag, disables the bridge, retries after the retry time.
// - thermal trip disables bridge, pump, analog regulator; resumes when it clears.
// - pin variant uses 25 us off time, regulation on, 100% reference, gain 19.8.
// - pin variant decodes six gate current levels from the select input.
// - six trip levels decoded; five pick 0.06 to 0.96 V, top disables monitor.
// - device is awake while active or in the sleep entry delay; asleep the bridge, pump and both regulators are off.
// - sleep is entered after the sleep entry delay following the falling edge, or at once during the wake delay.
// - raising the sleep request wakes the device; outputs wait for the wake delay.
// - serial variant restores configuration defaults after supply lockout and wake.
// - while sleep request is low, bridge off with gates pulled to node and ground.
// - during the power-on delay all gates are held off by weak pulldowns.
// - mode pin is latched only at power-up and sleep exit.
// - watchdog flag sits at bit 6 of the read-only fault register at offset zero.
// - bit 7 of the fault register is the OR of bits 6 to 1.
`include "gate_supervisor_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module gate_driver_fault_supervisor
    import gate_supervisor_pkg::*;
#(
    parameter int WD_IVL0_US     = 10000,
    parameter int WD_IVL1_US     = 20000,
    parameter int WD_IVL2_US     = 50000,
    parameter int WD_IVL3_US     = 100000,
    parameter int RETRY_US       = 3000,
    parameter int SLEEP_DELAY_US = 100,
    parameter int WAKE_DELAY_US  = 1000,
    parameter int POWER_ON_US    = 1000
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // axi4-lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // fault sensing
    input  wire logic        drainTrip,
    input  wire logic        senseOverVolt,
    input  wire logic        gateStuckDetect,
    input  wire logic        thermalTrip,
    input  wire logic        supplyLowLockout,
    input  wire logic        pumpLowLockout,
    input  wire logic        overTempWarning,
    // pins
    input  wire logic        pinConfigured,
    input  wire logic        lowPowerRequest_n,
    input  wire logic [1:0]  modePin,
    input  wire logic [2:0]  gateCurrentSelect,
    input  wire logic [2:0]  drainTripSelect,
    // fault outputs
    output logic             watchdogTripOut_n,
    output logic             errorIndicator_n,
    // power and drive control
    output logic             bridgeEnable,
    output logic             pumpEnable,
    output logic             analogRegulatorEnable,
    output logic             logicRegulatorEnable,
    output logic             highGatePullToNode,
    output logic             lowGatePullToGround,
    output logic             gateWeakPulldown,
    // latched mode, decoded and fixed settings
    output logic [1:0]       controlMode,
    output logic [2:0]       gateCurrentCode,
    output logic [2:0]       drainTripCode,
    output logic             drainMonitorEnable,
    output logic [7:0]       chopOffTimeUs,
    output logic             currentRegEnable,
    output logic [7:0]       vrefScalePct,
    output logic [7:0]       ampGainX10
);

    localparam count_t WD_PULSE_CYC = count_t'(`GS_WD_PULSE_US * `GS_CLK_MHZ);
    localparam count_t RETRY_CYC    = count_t'(RETRY_US * `GS_CLK_MHZ);
    localparam count_t SLEEP_CYC    = count_t'(SLEEP_DELAY_US * `GS_CLK_MHZ);
    localparam count_t WAKE_CYC     = count_t'(WAKE_DELAY_US * `GS_CLK_MHZ);
    localparam count_t POWER_ON_CYC = count_t'(POWER_ON_US * `GS_CLK_MHZ);
    function automatic count_t intervalCycles(input logic [1:0] sel);
        unique case (sel)
            2'h0:    intervalCycles = count_t'(WD_IVL0_US * `GS_CLK_MHZ);
            2'h1:    intervalCycles = count_t'(WD_IVL1_US * `GS_CLK_MHZ);
            2'h2:    intervalCycles = count_t'(WD_IVL2_US * `GS_CLK_MHZ);
            default: intervalCycles = count_t'(WD_IVL3_US * `GS_CLK_MHZ);
        endcase
    endfunction : intervalCycles
    power_state_e powerState_reg;
    count_t       powerCnt_reg;
    count_t       wdCnt_reg;
    count_t       wdPulseCnt_reg;
    count_t       retryCnt_reg;
    logic         wdEnable_reg;
    logic [1:0]   wdInterval_reg;
    logic         wdHalt_reg;
    logic [6:0]   faultFlags_reg;
    logic         supplyLowSeen_reg;
    logic [1:0]   controlMode_reg;
    logic         bvalid_reg;
    logic [1:0]   bresp_reg;
    logic         rvalid_reg;
    logic [31:0]  rdata_reg;
    logic [1:0]   rresp_reg;

    logic         writeFire;
    logic         readFire;
    logic         ctlWrite;
    logic         clearErrors;
    logic         refresh;
    logic         wdExpire;
    logic         overload;
    logic         retryStart;
    logic         awake;
    logic         configDefaults;
    logic         modeLatch;
    logic [7:0]   faultByte;
    logic [31:0]  stateWord;
    // bus handshake: both write channels are taken in the same cycle
    assign awready   = awvalid && wvalid && !bvalid_reg;
    assign wready    = awready;
    assign writeFire = awready;
    assign arready   = !rvalid_reg;
    assign readFire  = arvalid && arready;
    assign bvalid    = bvalid_reg;
    assign bresp     = bresp_reg;
    assign rvalid    = rvalid_reg;
    assign rdata     = rdata_reg;
    assign rresp     = rresp_reg;
    assign ctlWrite    = writeFire && awaddr == `GS_ADDR_CONTROL && wstrb[0];
    assign clearErrors = ctlWrite && wdata[`GS_CTL_CLEAR];
    assign refresh     = readFire && araddr == `GS_ADDR_FAULT;
    assign wdExpire    = wdEnable_reg && wdCnt_reg == count_t'(1);
    assign overload    = drainTrip || senseOverVolt;
    assign retryStart  = awake && (overload || gateStuckDetect);
    assign awake       = powerState_reg == ST_ACTIVE || powerState_reg == ST_SLEEP_WAIT;
    assign modeLatch   = (powerState_reg == ST_POWER_ON || powerState_reg == ST_WAKE)
                         && powerCnt_reg == count_t'(0);
    // defaults return on lockout recovery and on wake, serial variant only
    assign configDefaults = !pinConfigured
                            && ((supplyLowSeen_reg && !supplyLowLockout)
                                || (powerState_reg == ST_WAKE && powerCnt_reg == count_t'(0)));

    assign faultByte = {|faultFlags_reg[6:1], faultFlags_reg};
    assign stateWord = {21'h0, retryCnt_reg != count_t'(0), wdHalt_reg,
                        powerState_reg == ST_SLEEP, drainTripCode,
                        gateCurrentCode, controlMode_reg};
    // sleep, wake and power-on sequencing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            powerState_reg <= ST_POWER_ON;
            powerCnt_reg   <= 32'h0;
        end else begin
            unique case (powerState_reg)
                ST_POWER_ON: begin
                    if (powerCnt_reg >= POWER_ON_CYC - count_t'(1)) begin
                        powerState_reg <= ST_ACTIVE;
                        powerCnt_reg   <= 32'h0;
                    end else begin
                        powerCnt_reg <= powerCnt_reg + count_t'(1);
                    end
                end
                ST_ACTIVE: begin
                    if (!lowPowerRequest_n) begin
                        powerState_reg <= ST_SLEEP_WAIT;
                        powerCnt_reg   <= 32'h0;
                    end
                end
                ST_SLEEP_WAIT: begin
                    if (lowPowerRequest_n) begin
                        powerState_reg <= ST_ACTIVE;
                    end else if (powerCnt_reg >= SLEEP_CYC - count_t'(1)) begin
                        powerState_reg <= ST_SLEEP;
                    end else begin
                        powerCnt_reg <= powerCnt_reg + count_t'(1);
                    end
                end
                ST_SLEEP: begin
                    if (lowPowerRequest_n) begin
                        powerState_reg <= ST_WAKE;
                        powerCnt_reg   <= 32'h0;
                    end
                end
                ST_WAKE: begin
                    if (!lowPowerRequest_n) begin
                        powerState_reg <= ST_SLEEP;
                    end else if (powerCnt_reg >= WAKE_CYC - count_t'(1)) begin
                        powerState_reg <= ST_ACTIVE;
                        powerCnt_reg   <= 32'h0;
                    end else begin
                        powerCnt_reg <= powerCnt_reg + count_t'(1);
                    end
                end
                default: begin
                    powerState_reg <= ST_POWER_ON;
                    powerCnt_reg   <= 32'h0;
                end
            endcase
        end
    end
    // the mode pin is sampled as the power-on or wake delay begins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            controlMode_reg <= MODE_PHASE_ENABLE;
        end else if (modeLatch) begin
            controlMode_reg <= modePin;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            supplyLowSeen_reg <= 1'b0;
        end else begin
            supplyLowSeen_reg <= supplyLowLockout;
        end
    end
    // software configuration
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wdEnable_reg   <= `GS_RST_WATCHDOG_ENABLE_BIT;
            wdInterval_reg <= `GS_RST_IVL;
        end else if (configDefaults) begin
            wdEnable_reg   <= `GS_RST_WATCHDOG_ENABLE_BIT;
            wdInterval_reg <= `GS_RST_IVL;
        end else if (wdExpire) begin
            wdEnable_reg <= 1'b0;
        end else if (ctlWrite && !pinConfigured) begin
            wdEnable_reg   <= wdata[`GS_CTL_WATCHDOG_ENABLE_BIT];
            wdInterval_reg <= wdata[`GS_CTL_IVL_MSB:`GS_CTL_IVL_LSB];
        end
    end
    // watchdog down-counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wdCnt_reg <= 32'h0;
        end else if (!wdEnable_reg) begin
            wdCnt_reg <= intervalCycles(ctlWrite ? wdata[`GS_CTL_IVL_MSB:`GS_CTL_IVL_LSB]
                                                 : wdInterval_reg);
        end else if (refresh) begin
            wdCnt_reg <= intervalCycles(wdInterval_reg);
        end else if (wdCnt_reg != count_t'(0)) begin
            wdCnt_reg <= wdCnt_reg - count_t'(1);
        end
    end
    // trip pulse and bridge halt
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wdPulseCnt_reg <= 32'h0;
        end else if (wdExpire) begin
            wdPulseCnt_reg <= WD_PULSE_CYC;
        end else if (wdPulseCnt_reg != count_t'(0)) begin
            wdPulseCnt_reg <= wdPulseCnt_reg - count_t'(1);
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wdHalt_reg <= 1'b0;
        end else if (wdExpire) begin
            wdHalt_reg <= 1'b1;
        end else if (clearErrors) begin
            wdHalt_reg <= 1'b0;
        end
    end
    // retry interval after overload or stuck gate
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            retryCnt_reg <= 32'h0;
        end else if (retryStart && bridgeEnable) begin
            retryCnt_reg <= RETRY_CYC;
        end else if (retryCnt_reg != count_t'(0)) begin
            retryCnt_reg <= retryCnt_reg - count_t'(1);
        end
    end
    // sticky fault flags, a new event wins over a clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            faultFlags_reg <= 7'h00;
        end else begin
            faultFlags_reg <= (clearErrors ? 7'h00 : faultFlags_reg)
                | {wdExpire, awake && gateStuckDetect, awake && overload,
                   supplyLowLockout, pumpLowLockout, thermalTrip, overTempWarning};
        end
    end
    // write response
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `GS_RESP_OKAY;
        end else if (writeFire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= awaddr == `GS_ADDR_CONTROL ? `GS_RESP_OKAY : `GS_RESP_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end
    // read response
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0;
            rresp_reg  <= `GS_RESP_OKAY;
        end else if (readFire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= `GS_RESP_OKAY;
            unique case (araddr)
                `GS_ADDR_FAULT:   rdata_reg <= {24'h0, faultByte};
                `GS_ADDR_CONTROL: rdata_reg <= {28'h0, wdEnable_reg, wdInterval_reg, 1'b0};
                `GS_ADDR_STATE:   rdata_reg <= stateWord;
                default: begin
                    rdata_reg <= 32'h0;
                    rresp_reg <= `GS_RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end
    // drive and supply control
    assign bridgeEnable = powerState_reg == ST_ACTIVE && !wdHalt_reg
                          && retryCnt_reg == count_t'(0) && lowPowerRequest_n
                          && !thermalTrip && !supplyLowLockout && !pumpLowLockout;
    assign pumpEnable            = awake && !thermalTrip && !supplyLowLockout;
    assign analogRegulatorEnable = pumpEnable;
    assign logicRegulatorEnable  = powerState_reg != ST_SLEEP;
    assign highGatePullToNode    = !lowPowerRequest_n || powerState_reg == ST_SLEEP;
    assign lowGatePullToGround   = highGatePullToNode;
    assign gateWeakPulldown      = powerState_reg == ST_POWER_ON;

    assign watchdogTripOut_n = wdPulseCnt_reg == count_t'(0);
    assign errorIndicator_n  = !(wdHalt_reg || retryCnt_reg != count_t'(0)
                                 || thermalTrip || supplyLowLockout || pumpLowLockout);
    // fixed pin-variant settings and six-level decodes
    assign controlMode        = controlMode_reg;
    assign gateCurrentCode    = gateCurrentSelect > 3'h5 ? 3'h5 : gateCurrentSelect;
    assign drainTripCode      = drainTripSelect > `GS_VDS_DISABLED ? `GS_VDS_DISABLED
                                                                   : drainTripSelect;
    assign drainMonitorEnable = drainTripCode != `GS_VDS_DISABLED;
    assign chopOffTimeUs      = 8'(`GS_CHOP_OFF_US);
    assign currentRegEnable   = 1'b1;
    assign vrefScalePct       = 8'(`GS_VREF_PCT);
    assign ampGainX10         = 8'(`GS_AMP_GAIN_X10);

endmodule : gate_driver_fault_supervisor

`default_nettype wire

// ===== tb/mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
    // clock
    input  wire logic        clk,
    // write channels
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // read channels
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    // released lines carry the inverse so a stale value is never mistaken for data
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge clk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        awaddr <= ~a;
        wdata <= ~{24'h0, d};
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : mcu_model
`default_nettype wire

// ===== tb/supervisor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_properties (
    // clock and reset
    input wire logic       clk,
    input wire logic       arst_n,
    // inputs
    input wire logic       lowPowerRequest_n,
    input wire logic       thermalTrip,
    input wire logic       drainTrip,
    // outputs
    input wire logic       watchdogTripOut_n,
    input wire logic       errorIndicator_n,
    input wire logic       bridgeEnable,
    input wire logic       pumpEnable,
    input wire logic       analogRegulatorEnable,
    input wire logic       logicRegulatorEnable,
    input wire logic       highGatePullToNode,
    input wire logic       gateWeakPulldown,
    input wire logic [2:0] drainTripCode,
    input wire logic       drainMonitorEnable,
    input wire logic [7:0] chopOffTimeUs,
    input wire logic [7:0] ampGainX10
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [11:0] lowCnt;
    // length of the current low pulse on the trip output
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lowCnt <= 12'h000;
        end else begin
            lowCnt <= watchdogTripOut_n ? 12'h000 : lowCnt + 12'h001;
        end
    end
    sequence tripStart;
        $fell(watchdogTripOut_n);
    endsequence
    trip_len_a: assert property ($rose(watchdogTripOut_n) |-> lowCnt == 12'hC80)
        else $error("trip pulse length");
    trip_halt_a: assert property (tripStart |-> !bridgeEnable && !errorIndicator_n)
        else $error("trip without halt");
    trip_supply_a: assert property (tripStart and (lowPowerRequest_n && !thermalTrip)
        |-> pumpEnable && analogRegulatorEnable && logicRegulatorEnable)
        else $error("supply lost on trip");
    overload_stop_a: assert property ($rose(drainTrip) && bridgeEnable
        |-> ##[0:2] (!bridgeEnable && !errorIndicator_n))
        else $error("overload not stopped");
    thermal_off_a: assert property (thermalTrip && $past(thermalTrip) && !highGatePullToNode
        |-> !bridgeEnable && !pumpEnable && !analogRegulatorEnable)
        else $error("thermal not stopped");
    sleep_pull_a: assert property (!lowPowerRequest_n |-> highGatePullToNode && !bridgeEnable)
        else $error("sleep pull missing");
    power_hold_a: assert property (gateWeakPulldown |-> !bridgeEnable)
        else $error("drive in power-on");
    fixed_set_a: assert property (chopOffTimeUs == 8'h19 && ampGainX10 == 8'hC6)
        else $error("fixed setting wrong");
    monitor_off_a: assert property (drainMonitorEnable == (drainTripCode != 3'h5))
        else $error("monitor enable wrong");
endmodule : supervisor_properties
bind gate_driver_fault_supervisor supervisor_properties u_supervisor_properties (
    .clk, .arst_n, .lowPowerRequest_n, .thermalTrip, .drainTrip, .watchdogTripOut_n,
    .errorIndicator_n, .bridgeEnable, .pumpEnable, .analogRegulatorEnable,
    .logicRegulatorEnable, .highGatePullToNode, .gateWeakPulldown, .drainTripCode,
    .drainMonitorEnable, .chopOffTimeUs, .ampGainX10
);
`default_nettype wire

// ===== tb/test_gate_driver_fault_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module test_gate_driver_fault_supervisor import gate_supervisor_pkg::*;;
    logic clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, drainTrip, senseOverVolt, gateStuckDetect, thermalTrip;
    logic supplyLowLockout, pumpLowLockout, overTempWarning, pinConfigured, lowPowerRequest_n;
    logic watchdogTripOut_n, errorIndicator_n, bridgeEnable, pumpEnable, analogRegulatorEnable;
    logic logicRegulatorEnable, highGatePullToNode, lowGatePullToGround, gateWeakPulldown;
    logic drainMonitorEnable, currentRegEnable;
    logic [7:0] awaddr, araddr, chopOffTimeUs, vrefScalePct, ampGainX10;
    logic [31:0] wdata, rdata, rdVal;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, modePin, controlMode, resp;
    logic [2:0] gateCurrentSelect, drainTripSelect, gateCurrentCode, drainTripCode;
    int error_cnt = 0;
    int samples_checked = 0;
    int k;
    gate_driver_fault_supervisor #(.WD_IVL0_US(2), .RETRY_US(2), .SLEEP_DELAY_US(1),
        .WAKE_DELAY_US(1), .POWER_ON_US(1)) u_gate_driver_fault_supervisor (.*);
    mcu_model u_mcu_model (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);
    task automatic final_report;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        u_mcu_model.rd(a, rdVal, resp);
        check(rdVal, {24'h0, e});
    endtask : rdchk
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #240000;
        error_cnt++;
        final_report;
    end
    initial begin
        {arst_n, drainTrip, senseOverVolt, gateStuckDetect, thermalTrip, pinConfigured} = '0;
        {supplyLowLockout, pumpLowLockout, overTempWarning, modePin} = '0;
        {gateCurrentSelect, drainTripSelect} = '0;
        lowPowerRequest_n = 1'b1;
        cyc(8);
        arst_n <= 1'b1;
        cyc(60);
        check(gateWeakPulldown, 1'b0);
        rdchk(8'h08, 8'h00);
        cyc(300);
        check(watchdogTripOut_n, 1'b1);
        u_mcu_model.wr(8'h08, 8'h08, resp);
        repeat (2) begin
            cyc(80);
            rdchk(8'h00, 8'h00);
        end
        cyc(40);
        rdchk(8'h0C, 8'h00);
        for (k = 0; k < 200 && watchdogTripOut_n; k++) @(posedge clk);
        check(k >= 50 && k <= 65, 1'b1);
        check({bridgeEnable, errorIndicator_n}, 2'b00);
        rdchk(8'h00, 8'hC0);
        rdchk(8'h08, 8'h00);
        cyc(3300);
        check({watchdogTripOut_n, bridgeEnable, pumpEnable}, 3'b101);
        u_mcu_model.wr(8'h08, 8'h01, resp);
        cyc(2);
        check({bridgeEnable, errorIndicator_n}, 2'b11);
        rdchk(8'h00, 8'h00);
        for (int i = 0; i < 3; i++) begin
            {gateStuckDetect, senseOverVolt, drainTrip} <= 3'h1 << i;
            cyc(1);
            {gateStuckDetect, senseOverVolt, drainTrip} <= 3'h0;
            cyc(3);
            check({bridgeEnable, errorIndicator_n, pumpEnable}, 3'b001);
            cyc(110);
            check({bridgeEnable, errorIndicator_n}, 2'b11);
            rdchk(8'h00, i == 2 ? 8'hA0 : 8'h90);
            u_mcu_model.wr(8'h08, 8'h01, resp);
        end
        thermalTrip <= 1'b1;
        overTempWarning <= 1'b1;
        cyc(3);
        check({pumpEnable, analogRegulatorEnable, logicRegulatorEnable}, 3'b001);
        thermalTrip <= 1'b0;
        cyc(3);
        check({bridgeEnable, pumpEnable, errorIndicator_n}, 3'b111);
        rdchk(8'h00, 8'h83);
        overTempWarning <= 1'b0;
        u_mcu_model.wr(8'h08, 8'h01, resp);
        pinConfigured <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            gateCurrentSelect <= 3'(s);
            drainTripSelect <= 3'(s);
            cyc(2);
            check(gateCurrentCode, s > 5 ? 3'h5 : 3'(s));
            check({drainTripCode, drainMonitorEnable}, {s > 5 ? 3'h5 : 3'(s), s < 5});
        end
        check({currentRegEnable, vrefScalePct}, 9'h164);
        pinConfigured <= 1'b0;
        u_mcu_model.wr(8'h08, 8'h04, resp);
        {supplyLowLockout, pumpLowLockout} <= 2'b11;
        cyc(3);
        check(errorIndicator_n, 1'b0);
        {supplyLowLockout, pumpLowLockout} <= 2'b00;
        cyc(3);
        rdchk(8'h08, 8'h00);
        rdchk(8'h00, 8'h8C);
        u_mcu_model.wr(8'h08, 8'h01, resp);
        u_mcu_model.wr(8'h08, 8'h04, resp);
        modePin <= 2'h2;
        cyc(3);
        check(controlMode, 2'h0);
        lowPowerRequest_n <= 1'b0;
        cyc(2);
        check({highGatePullToNode, lowGatePullToGround, bridgeEnable}, 3'b110);
        cyc(10);
        check(logicRegulatorEnable, 1'b1);
        cyc(60);
        check({pumpEnable, analogRegulatorEnable, logicRegulatorEnable}, 3'b000);
        lowPowerRequest_n <= 1'b1;
        cyc(10);
        check(bridgeEnable, 1'b0);
        cyc(60);
        check({controlMode, bridgeEnable}, 3'b101);
        rdchk(8'h08, 8'h00);
        u_mcu_model.rd(8'h04, rdVal, resp);
        check(resp, 2'h2);
        u_mcu_model.wr(8'h00, 8'hFF, resp);
        check(resp, 2'h2);
        final_report;
    end
endmodule : test_gate_driver_fault_supervisor
`default_nettype wire
